// ==== verilog/asr_defs.vh ====
// Register offsets, bit positions and reset values for the async serial port
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH

`define ASR_ADDR_W 4
`define ASR_OFF_RCV_STAT 4'h0
`define ASR_OFF_TX_BUF 4'h1
`define ASR_OFF_TX_STAT 4'h2
`define ASR_OFF_BAUD_CTRL 4'h3
`define ASR_OFF_DIV_HIGH 4'h4
`define ASR_OFF_DIV_LOW 4'h5
`define ASR_OFF_RX_BUF 4'h6
`define ASR_OFF_PERIPH_FLAG 4'h7
`define ASR_OFF_PERIPH_EN 4'h8
`define ASR_OFF_IRQ_CTRL 4'h9

// Receive status/control bits
`define ASR_RS_SERIAL_PORT_ENABLE 7
`define ASR_RS_RX9 6
`define ASR_RS_CONTINUOUS_RECEIVE_ENABLE 4
`define ASR_RS_FRAMING_ERROR 2
`define ASR_RS_OVERRUN_ERROR 1
`define ASR_RS_RECEIVED_NINTH_BIT 0
// Transmit status/control bits
`define ASR_TS_TX9 6
`define ASR_TS_TRANSMIT_ENABLE 5
`define ASR_TS_SYNC 4
`define ASR_TS_HIGH_SPEED_BAUD_SELECT 2
`define ASR_TS_SHIFT_REGISTER_EMPTY 1
`define ASR_TS_TRANSMIT_NINTH_BIT 0
// Baud control bits
`define ASR_BC_WIDE_BAUD_GENERATOR_SELECT 3
// Peripheral flag / enable bits
`define ASR_PF_RECEIVE_COMPLETE_FLAG 5
`define ASR_PF_TRANSMIT_BUFFER_EMPTY_FLAG 4
// Interrupt control bits
`define ASR_IC_GIE 7
`define ASR_IC_PERIPHERAL_IRQ_ENABLE 6

`define ASR_RST_BYTE 8'h00
`define ASR_RST_TX_STAT 8'h02
`define ASR_OVS_LAST 4'hf
`define ASR_OVS_MID 4'h7
`define ASR_PRE64_LAST 2'h3
`define ASR_TX_CNT_8 4'h9
`define ASR_TX_CNT_9 4'ha
`define ASR_RX_LAST_8 4'h7
`define ASR_RX_LAST_9 4'h8
`define ASR_TRANSMIT_BUFFER_EMPTY_FLAG_SETTLE 2'h2

`endif

// ==== verilog/asr_baud_gen.v ====
// Baud tick generator: 8/16-bit divider of ref_clk with x16 sample ticks
`timescale 1ns/1ps
`include "asr_defs.vh"
module asr_baud_gen
(
  input wire ref_clk,
  input wire reset,
  input wire run,
  input wire wide_sel,
  input wire high_speed,
  input wire [15:0] divisor,
  output reg tick16_reg
);
  reg [15:0] cnt_reg;
  reg [1:0] pre_reg;
  wire [15:0] limit;
  wire div_done;
  wire x64;

  // Divider of 8 or 16 bits from the divisor pair
  assign limit = wide_sel ? divisor : {8'h00, divisor[7:0]};
  assign div_done = (cnt_reg == 16'h0000);
  // Without either select bit the generator runs at x64; prescale by four
  assign x64 = ~wide_sel & ~high_speed;

  always @(posedge ref_clk)
  begin
    if (reset || !run)
    begin
      cnt_reg <= 16'h0000;
      pre_reg <= 2'h0;
      tick16_reg <= 1'b0;
    end
    else
    begin
      tick16_reg <= 1'b0;
      if (div_done)
      begin
        cnt_reg <= limit;
        if (!x64 || pre_reg == `ASR_PRE64_LAST)
        begin
          pre_reg <= 2'h0;
          tick16_reg <= 1'b1;
        end
        else
          pre_reg <= pre_reg + 2'h1;
      end
      else
        cnt_reg <= cnt_reg - 16'h0001;
    end
  end
endmodule // asr_baud_gen

// ==== verilog/asr_receiver.v ====
// Receiver: x16 data recovery and frame shifter
`timescale 1ns/1ps
`include "asr_defs.vh"
module asr_receiver
(
  input wire ref_clk,
  input wire reset,
  input wire run,
  input wire tick16,
  input wire nine_bit,
  input wire rx_in,
  output reg done_reg,
  output reg [8:0] data_reg,
  output reg stop_ok_reg
);
  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;
  reg [1:0] state_reg;
  reg [3:0] ovs_reg;
  reg [3:0] bit_reg;
  wire mid;

  assign mid = tick16 && (ovs_reg == `ASR_OVS_MID);

  // Sample at x16; one bit decision per sixteen ticks
  always @(posedge ref_clk)
  begin
    if (reset || !run)
    begin
      state_reg <= ST_IDLE;
      ovs_reg <= 4'h0;
      bit_reg <= 4'h0;
      done_reg <= 1'b0;
      data_reg <= 9'h000;
      stop_ok_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (tick16 && state_reg != ST_IDLE)
        ovs_reg <= ovs_reg + 4'h1;
      case (state_reg)
        ST_IDLE:
          if (!rx_in)
          begin
            state_reg <= ST_START;
            ovs_reg <= 4'h0;
          end
        ST_START:
          if (mid)
          begin
            // Glitch shorter than half a bit is rejected
            state_reg <= rx_in ? ST_IDLE : ST_DATA;
            bit_reg <= 4'h0;
          end
        ST_DATA:
          if (mid)
          begin
            // LSb arrives first; shift in from the top
            if (nine_bit)
              data_reg <= {rx_in, data_reg[8:1]};
            else
              data_reg <= {1'b0, rx_in, data_reg[7:1]};
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == (nine_bit ? `ASR_RX_LAST_9 : `ASR_RX_LAST_8))
              state_reg <= ST_STOP;
          end
        default:
          if (mid)
          begin
            stop_ok_reg <= rx_in;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
      endcase
    end
  end
endmodule // asr_receiver

// ==== verilog/asr_serial_port.v ====
// Async serial port top: registers, transmitter, receive buffer and flags
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "asr_defs.vh"
module asr_serial_port
(
  input wire ref_clk,
  input wire reset,
  input wire [`ASR_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_reg,
  input wire rx_pin,
  output reg tx_pin_reg,
  output reg tx_pin_oe_reg,
  output reg irq_reg
);
  localparam TX_IDLE = 2'd0;
  localparam TX_LOAD = 2'd1;
  localparam TX_SHIFT = 2'd2;

  reg [7:0] rcv_ctrl_reg;
  reg [7:0] tx_ctrl_reg;
  reg [7:0] baud_ctrl_reg;
  reg [7:0] div_high_reg;
  reg [7:0] div_low_reg;
  reg [7:0] periph_en_reg;
  reg [7:0] irq_ctrl_reg;
  reg [7:0] transmit_buffer_reg;
  reg transmit_ninth_bit_reg;
  reg buf_full_reg;
  reg [1:0] transmit_buffer_empty_flag_hold_reg;
  reg [10:0] transmit_shift_register_reg;
  reg [3:0] tx_bits_reg;
  reg [3:0] tx_ovs_reg;
  reg [1:0] tx_state_reg;
  reg [7:0] receive_buffer_reg;
  reg received_ninth_bit_reg;
  reg receive_complete_flag_reg;
  reg framing_error_reg;
  reg overrun_error_reg;
  reg rx_s1_reg;
  reg rx_s2_reg;
  reg rx_s3_reg;
  reg rx_clean_reg;
  reg [7:0] rdata_next;

  wire port_on;
  wire tx_on;
  wire rx_on;
  wire tick16;
  wire rx_done;
  wire [8:0] rx_data;
  wire rx_stop_ok;
  wire shifter_empty;
  wire buffer_empty_flag;
  wire wr_txbuf;
  wire rd_rxbuf;

  // Index match shared by the strobe decoders
  function addr_hit;
    input [`ASR_ADDR_W-1:0] a;
    input [`ASR_ADDR_W-1:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // Shift count for one frame: start plus eight or nine data bits
  function [3:0] frame_count;
    input nine;
    begin
      frame_count = nine ? `ASR_TX_CNT_9 : `ASR_TX_CNT_8;
    end
  endfunction

  // Port alive only with enable set and clocked mode clear
  assign port_on = rcv_ctrl_reg[`ASR_RS_SERIAL_PORT_ENABLE] & ~tx_ctrl_reg[`ASR_TS_SYNC];
  assign tx_on = port_on & tx_ctrl_reg[`ASR_TS_TRANSMIT_ENABLE];
  assign rx_on = port_on & rcv_ctrl_reg[`ASR_RS_CONTINUOUS_RECEIVE_ENABLE];
  assign wr_txbuf = reg_write && addr_hit(reg_addr, `ASR_OFF_TX_BUF);
  assign rd_rxbuf = reg_read && addr_hit(reg_addr, `ASR_OFF_RX_BUF);
  assign shifter_empty = (tx_state_reg != TX_SHIFT);
  // Flag set regardless of its enable; held low until settle counter ends
  // Low while the transmitter is off, so enabling it sets the flag at once
  assign buffer_empty_flag = tx_on & ~buf_full_reg & (transmit_buffer_empty_flag_hold_reg == 2'h0);

  // One generator feeds both directions
  asr_baud_gen u_baud
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(port_on),
    .wide_sel(baud_ctrl_reg[`ASR_BC_WIDE_BAUD_GENERATOR_SELECT]),
    .high_speed(tx_ctrl_reg[`ASR_TS_HIGH_SPEED_BAUD_SELECT]),
    .divisor({div_high_reg, div_low_reg}),
    .tick16_reg(tick16)
  );

  asr_receiver u_rx
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(rx_on && !overrun_error_reg),
    .tick16(tick16),
    .nine_bit(rcv_ctrl_reg[`ASR_RS_RX9]),
    .rx_in(rx_clean_reg),
    .done_reg(rx_done),
    .data_reg(rx_data),
    .stop_ok_reg(rx_stop_ok)
  );

  // Three-stage pin sync; change accepted when stages two and three agree
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_clean_reg <= 1'b1;
    end
    else
    begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg)
        rx_clean_reg <= rx_s3_reg;
    end
  end

  // Register writes
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      rcv_ctrl_reg <= `ASR_RST_BYTE;
      tx_ctrl_reg <= `ASR_RST_BYTE;
      baud_ctrl_reg <= `ASR_RST_BYTE;
      div_high_reg <= `ASR_RST_BYTE;
      div_low_reg <= `ASR_RST_BYTE;
      periph_en_reg <= `ASR_RST_BYTE;
      irq_ctrl_reg <= `ASR_RST_BYTE;
      transmit_buffer_reg <= `ASR_RST_BYTE;
      transmit_ninth_bit_reg <= 1'b0;
    end
    else if (reg_write)
    begin
      if (reg_addr == `ASR_OFF_RCV_STAT)
        rcv_ctrl_reg <= reg_wdata;
      else if (reg_addr == `ASR_OFF_TX_STAT)
      begin
        tx_ctrl_reg <= reg_wdata;
        // Ninth bit must be written before the data byte
        transmit_ninth_bit_reg <= reg_wdata[`ASR_TS_TRANSMIT_NINTH_BIT];
      end
      else if (reg_addr == `ASR_OFF_BAUD_CTRL)
        baud_ctrl_reg <= reg_wdata;
      else if (reg_addr == `ASR_OFF_DIV_HIGH)
        div_high_reg <= reg_wdata;
      else if (reg_addr == `ASR_OFF_DIV_LOW)
        div_low_reg <= reg_wdata;
      else if (reg_addr == `ASR_OFF_PERIPH_EN)
        periph_en_reg <= reg_wdata;
      else if (reg_addr == `ASR_OFF_IRQ_CTRL)
        irq_ctrl_reg <= reg_wdata;
      else if (reg_addr == `ASR_OFF_TX_BUF)
        transmit_buffer_reg <= reg_wdata;
    end
  end

  // Transmit buffer handoff and shifter
  always @(posedge ref_clk)
  begin
    if (reset || !tx_on)
    begin
      buf_full_reg <= 1'b0;
      transmit_buffer_empty_flag_hold_reg <= 2'h0;
      tx_state_reg <= TX_IDLE;
      transmit_shift_register_reg <= 11'h7ff;
      tx_bits_reg <= 4'h0;
      tx_ovs_reg <= 4'h0;
    end
    else
    begin
      if (transmit_buffer_empty_flag_hold_reg != 2'h0)
        transmit_buffer_empty_flag_hold_reg <= transmit_buffer_empty_flag_hold_reg - 2'h1;
      if (wr_txbuf)
      begin
        // A write starts transmission; flag settles two cycles later
        buf_full_reg <= 1'b1;
        transmit_buffer_empty_flag_hold_reg <= `ASR_TRANSMIT_BUFFER_EMPTY_FLAG_SETTLE;
      end
      case (tx_state_reg)
        TX_IDLE:
          if (buf_full_reg)
            tx_state_reg <= TX_LOAD;
        TX_LOAD:
        begin
          // One-cycle move frees the buffer
          // Frame: stop, optional ninth, data, start; parity never computed
          if (tx_ctrl_reg[`ASR_TS_TX9])
            transmit_shift_register_reg <= {1'b1, transmit_ninth_bit_reg,
              transmit_buffer_reg, 1'b0};
          else
            transmit_shift_register_reg <= {2'b11, transmit_buffer_reg, 1'b0};
          tx_bits_reg <= frame_count(tx_ctrl_reg[`ASR_TS_TX9]);
          tx_ovs_reg <= 4'h0;
          if (!wr_txbuf)
            buf_full_reg <= 1'b0;
          tx_state_reg <= TX_SHIFT;
        end
        default:
          if (tick16)
          begin
            tx_ovs_reg <= tx_ovs_reg + 4'h1;
            if (tx_ovs_reg == `ASR_OVS_LAST)
            begin
              // LSb first out of the bottom
              transmit_shift_register_reg <= {1'b1, transmit_shift_register_reg[10:1]};
              if (tx_bits_reg == 4'h0)
                // Reload only after stop bit has gone
                tx_state_reg <= buf_full_reg ? TX_LOAD : TX_IDLE;
              else
                tx_bits_reg <= tx_bits_reg - 4'h1;
            end
          end
      endcase
    end
  end

  // Receive buffer, flags and errors
  always @(posedge ref_clk)
  begin
    if (reset || !port_on)
    begin
      receive_buffer_reg <= `ASR_RST_BYTE;
      received_ninth_bit_reg <= 1'b0;
      receive_complete_flag_reg <= 1'b0;
      framing_error_reg <= 1'b0;
      overrun_error_reg <= 1'b0;
    end
    else
    begin
      if (rd_rxbuf)
        receive_complete_flag_reg <= 1'b0;
      if (!rcv_ctrl_reg[`ASR_RS_CONTINUOUS_RECEIVE_ENABLE])
      begin
        framing_error_reg <= 1'b0;
        overrun_error_reg <= 1'b0;
      end
      else if (rx_done)
      begin
        if (receive_complete_flag_reg && !rd_rxbuf)
          overrun_error_reg <= 1'b1;
        else
        begin
          // Completion set wins over a same-cycle read
          receive_complete_flag_reg <= 1'b1;
          receive_buffer_reg <= rx_data[7:0];
          received_ninth_bit_reg <= rx_data[8] & rcv_ctrl_reg[`ASR_RS_RX9];
          framing_error_reg <= ~rx_stop_ok;
        end
      end
    end
  end

  // Read mux; data appears the cycle after the strobe
  always @*
  begin
    rdata_next = 8'h00;
    if (reg_addr == `ASR_OFF_RCV_STAT)
      rdata_next = {rcv_ctrl_reg[7:3], framing_error_reg, overrun_error_reg,
        received_ninth_bit_reg};
    else if (reg_addr == `ASR_OFF_TX_STAT)
      rdata_next = {tx_ctrl_reg[7:2], shifter_empty, tx_ctrl_reg[0]};
    else if (reg_addr == `ASR_OFF_BAUD_CTRL)
      rdata_next = baud_ctrl_reg;
    else if (reg_addr == `ASR_OFF_DIV_HIGH)
      rdata_next = div_high_reg;
    else if (reg_addr == `ASR_OFF_DIV_LOW)
      rdata_next = div_low_reg;
    else if (reg_addr == `ASR_OFF_RX_BUF)
      rdata_next = receive_buffer_reg;
    else if (reg_addr == `ASR_OFF_PERIPH_FLAG)
      rdata_next = {2'b00, receive_complete_flag_reg, buffer_empty_flag, 4'h0};
    else if (reg_addr == `ASR_OFF_PERIPH_EN)
      rdata_next = periph_en_reg;
    else if (reg_addr == `ASR_OFF_IRQ_CTRL)
      rdata_next = irq_ctrl_reg;
    else if (reg_addr == `ASR_OFF_TX_BUF)
      rdata_next = transmit_buffer_reg;
  end

  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      reg_rdata_reg <= 8'h00;
      tx_pin_reg <= 1'b1;
      tx_pin_oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      reg_rdata_reg <= reg_read ? rdata_next : 8'h00;
      // Idle high outside a frame pin released when port off
      // Gated by tx_on so a frame cut by disable never leaves the line low
      tx_pin_reg <= (tx_on && tx_state_reg == TX_SHIFT) ? transmit_shift_register_reg[0] : 1'b1;
      tx_pin_oe_reg <= port_on;
      // Gated by each enable and the global pair
      irq_reg <= irq_ctrl_reg[`ASR_IC_GIE] & irq_ctrl_reg[`ASR_IC_PERIPHERAL_IRQ_ENABLE] &
        ((receive_complete_flag_reg & periph_en_reg[`ASR_PF_RECEIVE_COMPLETE_FLAG]) |
        (buffer_empty_flag & tx_on & periph_en_reg[`ASR_PF_TRANSMIT_BUFFER_EMPTY_FLAG]));
    end
  end
endmodule // asr_serial_port

// ==== testbench/asr_serial_port_sva.sv ====
// Checker for the async serial port pins and register port
`timescale 1ns/1ps
`include "asr_defs.vh"
module asr_serial_port_sva
(
  input wire ref_clk,
  input wire reset,
  input wire [`ASR_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata_reg,
  input wire rx_pin,
  input wire tx_pin_reg,
  input wire tx_pin_oe_reg,
  input wire irq_reg
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata_reg == 8'h00)
    else $error("read data not zero outside an answer");
  a_idle_when_off: assert property (!tx_pin_oe_reg |-> tx_pin_reg)
    else $error("tx line low while port off");
  a_irq_port_off: assert property (!tx_pin_oe_reg && $past(!tx_pin_oe_reg) |-> !irq_reg)
    else $error("irq while port off");
  // Fastest setting is one tick a clock, so no bit is under 16 clocks
  a_start_bit_len: assert property ($fell(tx_pin_reg) |-> !tx_pin_reg [*8] ##1 !tx_pin_reg [*8])
    else $error("start bit too short");
  a_bit_min_hold: assert property ($changed(tx_pin_reg) |=>
    ($stable(tx_pin_reg) || !tx_pin_oe_reg) [*8] ##1
    ($stable(tx_pin_reg) || !tx_pin_oe_reg) [*7])
    else $error("tx bit too short");
  a_read_clears_receive_complete_flag: assert property (reg_read && reg_addr == `ASR_OFF_RX_BUF ##1
    reg_read && reg_addr == `ASR_OFF_PERIPH_FLAG |=> !reg_rdata_reg[`ASR_PF_RECEIVE_COMPLETE_FLAG])
    else $error("receive flag kept after buffer read");
  a_shift_register_empty_busy: assert property (reg_read && reg_addr == `ASR_OFF_TX_STAT && !tx_pin_reg
    |=> !reg_rdata_reg[`ASR_TS_SHIFT_REGISTER_EMPTY])
    else $error("shifter empty mid frame");
  a_transmit_buffer_empty_flag_settle: assert property (reg_write && reg_addr == `ASR_OFF_TX_BUF ##1
    reg_read && reg_addr == `ASR_OFF_PERIPH_FLAG |=> !reg_rdata_reg[`ASR_PF_TRANSMIT_BUFFER_EMPTY_FLAG])
    else $error("buffer empty flag right after write");
endmodule // asr_serial_port_sva
bind asr_serial_port asr_serial_port_sva chk_u (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata_reg(reg_rdata_reg), .rx_pin(rx_pin), .tx_pin_reg(tx_pin_reg),
  .tx_pin_oe_reg(tx_pin_oe_reg), .irq_reg(irq_reg));

// ==== testbench/asr_remote_link.sv ====
// Far-end serial transceiver model on the port's tx and rx lines
`timescale 1ns/1ps
module asr_remote_link
(
  input wire ref_clk,
  input wire tx_line,
  input wire nine,
  input wire [7:0] bit_len,
  output reg rx_line
);
  reg [9:0] words [0:7];
  reg [8:0] w;
  integer count = 0;
  integer i;
  initial
    rx_line = 1'b1;
  // Centre sampling leaves slack against the port's bit edges
  always
  begin
    @(negedge tx_line);
    w = 9'h000;
    repeat (bit_len / 2) @(posedge ref_clk);
    for (i = 0; i < (nine ? 9 : 8); i = i + 1)
    begin
      repeat (bit_len) @(posedge ref_clk);
      w[i] = tx_line;
    end
    repeat (bit_len) @(posedge ref_clk);
    words[count % 8] = {tx_line, w};
    count = count + 1;
  end
  task send(input [8:0] d, input n9, input stop_bit);
    integer k;
  begin
    rx_line <= 1'b0;
    repeat (bit_len) @(posedge ref_clk);
    for (k = 0; k < (n9 ? 9 : 8); k = k + 1)
    begin
      rx_line <= d[k];
      repeat (bit_len) @(posedge ref_clk);
    end
    rx_line <= stop_bit;
    repeat (bit_len) @(posedge ref_clk);
    rx_line <= 1'b1;
    repeat (bit_len) @(posedge ref_clk);
  end
  endtask
endmodule // asr_remote_link

// ==== testbench/tb_asr_serial_port.sv ====
// Register-level bench for the async serial port
`timescale 1ns/1ps
module tb_asr_serial_port;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg nine = 1'b0;
  reg [7:0] bit_len = 8'h10;
  wire [7:0] reg_rdata_reg;
  wire rx_pin;
  wire tx_pin_reg;
  wire tx_pin_oe_reg;
  wire irq_reg;
  integer failures = 0;
  integer num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  asr_serial_port dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_reg(reg_rdata_reg), .rx_pin(rx_pin), .tx_pin_reg(tx_pin_reg),
    .tx_pin_oe_reg(tx_pin_oe_reg), .irq_reg(irq_reg));
  // Divisor 0 at x16 gives 16 clocks a bit, matched here
  asr_remote_link link_u (.ref_clk(ref_clk), .tx_line(tx_pin_reg), .nine(nine),
    .bit_len(bit_len), .rx_line(rx_pin));
  task bus(input w, input r, input [3:0] a, input [7:0] d);
  begin
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  end
  endtask
  task idle;
    bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    bus(1'b1, 1'b0, a, d);
    idle;
  end
  endtask
  task check(input string nm, input [9:0] e, input [9:0] g);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // Answer stands only in the cycle after the strobe
  task rd(input [3:0] a, input [7:0] e);
  begin
    bus(1'b0, 1'b1, a, 8'h00);
    idle;
    check("rdata", e, reg_rdata_reg);
  end
  endtask
  task wait_cnt(input integer n);
    integer k;
  begin
    for (k = 0; k < 3000 && link_u.count < n; k = k + 1)
      idle;
    // A frame that never arrives counts as a mismatch
    if (link_u.count < n)
      check("frames", n, link_u.count);
    // Full bit time so the stop bit ends before any reconfiguration
    repeat (bit_len) idle;
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures = failures + 1;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    idle;
    rd(4'h2, 8'h02);
    rd(4'h0, 8'h00);
    rd(4'hf, 8'h00);
    rd(4'h7, 8'h00);
    $display("test reset done");
    wr(4'h5, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h3, 8'h08);
    wr(4'h0, 8'h90);
    wr(4'h2, 8'h24);
    rd(4'h7, 8'h10);
    check("oe", 1'b1, tx_pin_oe_reg);
    wr(4'h7, 8'h00);
    rd(4'h7, 8'h10);
    bus(1'b1, 1'b0, 4'h1, 8'ha5);
    bus(1'b0, 1'b1, 4'h7, 8'h00);
    idle;
    check("transmit_buffer_empty_flag", 1'b0, reg_rdata_reg[4]);
    repeat (3) idle;
    rd(4'h2, 8'h24);
    rd(4'h7, 8'h10);
    wr(4'h1, 8'h3c);
    rd(4'h7, 8'h00);
    wait_cnt(2);
    check("word0", 10'h2a5, link_u.words[0]);
    check("word1", 10'h23c, link_u.words[1]);
    rd(4'h2, 8'h26);
    check("idle", 1'b1, tx_pin_reg);
    wr(4'h2, 8'h65);
    nine <= 1'b1;
    wr(4'h1, 8'h81);
    wait_cnt(3);
    check("word2", 10'h381, link_u.words[2]);
    nine <= 1'b0;
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h20);
    bit_len <= 8'h40;
    wr(4'h1, 8'h96);
    wait_cnt(4);
    check("word3", 10'h296, link_u.words[3]);
    bit_len <= 8'h10;
    wr(4'h3, 8'h08);
    wr(4'h2, 8'h24);
    $display("test transmit done");
    wr(4'h8, 8'h20);
    wr(4'h9, 8'hc0);
    link_u.send(9'h05a, 1'b0, 1'b1);
    check("irq", 1'b1, irq_reg);
    rd(4'h7, 8'h30);
    rd(4'h0, 8'h90);
    bus(1'b0, 1'b1, 4'h6, 8'h00);
    bus(1'b0, 1'b1, 4'h7, 8'h00);
    check("rxbuf", 8'h5a, reg_rdata_reg);
    idle;
    check("flags", 8'h10, reg_rdata_reg);
    idle;
    check("irq", 1'b0, irq_reg);
    link_u.send(9'h011, 1'b0, 1'b1);
    link_u.send(9'h022, 1'b0, 1'b1);
    rd(4'h0, 8'h92);
    rd(4'h6, 8'h11);
    link_u.send(9'h033, 1'b0, 1'b1);
    rd(4'h7, 8'h10);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h80);
    wr(4'h0, 8'hd0);
    link_u.send(9'h1c3, 1'b1, 1'b0);
    rd(4'h0, 8'hd5);
    rd(4'h6, 8'hc3);
    $display("test receive done");
    wr(4'h2, 8'h34);
    idle;
    check("oe", 1'b0, tx_pin_oe_reg);
    check("idle", 1'b1, tx_pin_reg);
    $display("test mode done");
    give_verdict;
  end
endmodule // tb_asr_serial_port
